// >>> mie_consts.svh
// Constants for the instruction execute block of the 8-bit core
// Contract
// - Add literal to accumulator, store in accumulator, update all three flags, one cycle.
// - Add accumulator and file register, route to destination, update all three flags.
// - Destination bit zero writes accumulator, one writes file register; addresses 000h-1FFh.
// - AND literal into accumulator, only the zero flag changes, one cycle.
// - AND accumulator with file register, route by destination, only zero flag changes.
// - Bit clear forces the chosen bit of a file register to zero, no flags.
// - Bit set forces the chosen bit of a file register to one, no flags.
// - Bit test skips on clear or set; skipped instruction becomes a NOP, two cycles.
// - Clear file writes zero to the file register and sets the zero flag.
// - Clear accumulator writes zero to the accumulator and sets the zero flag.
// - Watchdog kick zeroes the watchdog counter and updates expiry and powerdown flags.
// - Complement inverts the file register, routes by destination, updates zero flag.
// - Decrement subtracts one, routes by destination, updates zero flag only.
// - Decrement-skip changes no flags; a zero result replaces the next instruction by NOP.
// - Increment adds one, routes by destination, updates zero flag only.
// - Increment-skip changes no flags; a zero result replaces the next instruction by NOP.
// - OR literal into accumulator and update the zero flag, one cycle.
// - OR accumulator with file register, route by destination, update zero flag.
// - Long call pushes pointer plus one, loads pointer from 13-bit immediate, two cycles.
// - Long jump loads pointer from 13-bit immediate, no stack or flags, two cycles.
// - Move copies file register to destination and updates zero flag, a zero test.
// - Out-bit flag is carry on addition, nibble flag the same at the nibble boundary.
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH

`define MIE_OPC_W 16
`define MIE_PP_W 13
`define MIE_FA_W 9
`define MIE_DATA_W 8
`define MIE_BIT_W 3
`define MIE_NIB_W 4
`define MIE_WDOG_W 8

`define MIE_GRP_HI 13
`define MIE_GRP_LO 12
`define MIE_SUB_HI 11
`define MIE_SUB_LO 8
`define MIE_DST_BIT 7
`define MIE_FHI_HI 15
`define MIE_FHI_LO 14
`define MIE_FLO_HI 6
`define MIE_BIT_HI 9
`define MIE_BIT_LO 7
`define MIE_BKIND_HI 11
`define MIE_BKIND_LO 10
`define MIE_JMP_BIT 11
`define MIE_TGT_LO_HI 10
`define MIE_LIT_HI 15
`define MIE_LIT_LO 8
`define MIE_IMM_HI 7

`define MIE_GRP_BYTE 2'h0
`define MIE_GRP_LIT 2'h1
`define MIE_GRP_BRANCH 2'h2
`define MIE_GRP_BIT 2'h3

`define MIE_SUB_CLR 4'h1
`define MIE_SUB_DEC 4'h3
`define MIE_SUB_OR 4'h4
`define MIE_SUB_AND 4'h5
`define MIE_SUB_ADD 4'h7
`define MIE_SUB_MOV 4'h8
`define MIE_SUB_COM 4'h9
`define MIE_SUB_INC 4'hA
`define MIE_SUB_DECSZ 4'hB
`define MIE_SUB_INCSZ 4'hF

`define MIE_BK_CLR 2'h0
`define MIE_BK_SET 2'h1
`define MIE_BK_SKC 2'h2
`define MIE_BK_SKS 2'h3

`define MIE_LIT_OR 8'h1A
`define MIE_LIT_AND 8'h1B
`define MIE_LIT_ADD 8'h1C
`define MIE_WORD_KICK 16'h1E04
`define MIE_WORD_CLRACC 16'h0140
`define MIE_WORD_NOP 16'h0000

`define MIE_PP_RST 13'h0000
`define MIE_ACC_RST 8'h00
`define MIE_FLAG_RST 1'b0
`define MIE_WDFLAG_RST 1'b1
`define MIE_PP_STEP 13'h0001

`endif

// >>> mie_pkg.sv
// Types shared by the instruction execute block
package mie_pkg;
  typedef enum logic [4:0] {
    op_nop, op_add_lit, op_and_lit, op_or_lit, op_add_f, op_and_f, op_or_f,
    op_clr_f, op_clr_acc, op_com_f, op_dec_f, op_decsz_f, op_inc_f, op_incsz_f,
    op_mov_f, op_bclr, op_bset, op_bskc, op_bsks, op_call, op_jump, op_kick
  } mie_op_t;
endpackage

// >>> mie_decode.sv
// Opcode decoder: splits a 16-bit opcode into operation and fields
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_decode (
  input wire logic [`MIE_OPC_W-1:0] opcode,
  output mie_pkg::mie_op_t op,
  output logic [`MIE_FA_W-1:0] fa,
  output logic dst_file,
  output logic [`MIE_BIT_W-1:0] bit_pos,
  output logic [`MIE_DATA_W-1:0] imm,
  output logic [`MIE_PP_W-1:0] target
);
  function automatic mie_pkg::mie_op_t byte_op(input logic [3:0] sub, input logic d);
    mie_pkg::mie_op_t r;
    r = mie_pkg::op_nop;
    case (sub)
      `MIE_SUB_ADD: r = mie_pkg::op_add_f;
      `MIE_SUB_AND: r = mie_pkg::op_and_f;
      `MIE_SUB_OR: r = mie_pkg::op_or_f;
      `MIE_SUB_CLR: r = d ? mie_pkg::op_clr_f : mie_pkg::op_nop;
      `MIE_SUB_COM: r = mie_pkg::op_com_f;
      `MIE_SUB_DEC: r = mie_pkg::op_dec_f;
      `MIE_SUB_DECSZ: r = mie_pkg::op_decsz_f;
      `MIE_SUB_INC: r = mie_pkg::op_inc_f;
      `MIE_SUB_INCSZ: r = mie_pkg::op_incsz_f;
      `MIE_SUB_MOV: r = mie_pkg::op_mov_f;
      default: r = mie_pkg::op_nop;
    endcase
    return r;
  endfunction

  // Nine-bit file address: two high bits sit above the group field
  assign fa = {opcode[`MIE_FHI_HI:`MIE_FHI_LO], opcode[`MIE_FLO_HI:0]};
  assign bit_pos = opcode[`MIE_BIT_HI:`MIE_BIT_LO];
  assign imm = opcode[`MIE_IMM_HI:0];
  assign target = {opcode[`MIE_FHI_HI:`MIE_FHI_LO], opcode[`MIE_TGT_LO_HI:0]};

  always_comb begin
    op = mie_pkg::op_nop;
    dst_file = opcode[`MIE_DST_BIT];
    case (opcode[`MIE_GRP_HI:`MIE_GRP_LO])
      `MIE_GRP_BYTE: begin
        if (opcode == `MIE_WORD_CLRACC) begin
          op = mie_pkg::op_clr_acc;
        end else begin
          op = byte_op(opcode[`MIE_SUB_HI:`MIE_SUB_LO], opcode[`MIE_DST_BIT]);
        end
      end
      `MIE_GRP_LIT: begin
        // Unimplemented literal and control words fall through as NOP
        if (opcode == `MIE_WORD_KICK) begin
          op = mie_pkg::op_kick;
        end else begin
          case (opcode[`MIE_LIT_HI:`MIE_LIT_LO])
            `MIE_LIT_ADD: op = mie_pkg::op_add_lit;
            `MIE_LIT_AND: op = mie_pkg::op_and_lit;
            `MIE_LIT_OR: op = mie_pkg::op_or_lit;
            default: op = mie_pkg::op_nop;
          endcase
        end
      end
      `MIE_GRP_BRANCH: begin
        op = opcode[`MIE_JMP_BIT] ? mie_pkg::op_jump : mie_pkg::op_call;
      end
      default: begin
        dst_file = 1'b1;
        case (opcode[`MIE_BKIND_HI:`MIE_BKIND_LO])
          `MIE_BK_CLR: op = mie_pkg::op_bclr;
          `MIE_BK_SET: op = mie_pkg::op_bset;
          `MIE_BK_SKC: op = mie_pkg::op_bskc;
          default: op = mie_pkg::op_bsks;
        endcase
      end
    endcase
  end
endmodule

// >>> mie_alu.sv
// Arithmetic and logic unit with carry, nibble carry and zero
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_alu #(
  parameter int DW = `MIE_DATA_W
) (
  input wire mie_pkg::mie_op_t op,
  input wire logic [DW-1:0] acc,
  input wire logic [DW-1:0] fval,
  input wire logic [DW-1:0] imm,
  input wire logic [`MIE_BIT_W-1:0] bit_pos,
  output logic [DW-1:0] result,
  output logic carry,
  output logic half,
  output logic zero,
  output logic bit_val
);
  logic [DW-1:0] operand;
  logic [DW:0] sum;
  logic [`MIE_NIB_W:0] nib_sum;
  logic [DW-1:0] mask;

  assign operand = (op == mie_pkg::op_add_lit) ? imm : fval;
  assign sum = {1'b0, acc} + {1'b0, operand};
  assign nib_sum = {1'b0, acc[`MIE_NIB_W-1:0]} + {1'b0, operand[`MIE_NIB_W-1:0]};
  assign carry = sum[DW];
  assign half = nib_sum[`MIE_NIB_W];
  assign mask = DW'(1) << bit_pos;
  assign bit_val = |(fval & mask);
  assign zero = (result == '0);

  always_comb begin
    case (op)
      mie_pkg::op_add_lit, mie_pkg::op_add_f: result = sum[DW-1:0];
      mie_pkg::op_and_lit: result = acc & imm;
      mie_pkg::op_and_f: result = acc & fval;
      mie_pkg::op_or_lit: result = acc | imm;
      mie_pkg::op_or_f: result = acc | fval;
      mie_pkg::op_clr_f, mie_pkg::op_clr_acc: result = '0;
      mie_pkg::op_com_f: result = ~fval;
      mie_pkg::op_dec_f, mie_pkg::op_decsz_f: result = fval - DW'(1);
      mie_pkg::op_inc_f, mie_pkg::op_incsz_f: result = fval + DW'(1);
      mie_pkg::op_bclr: result = fval & ~mask;
      mie_pkg::op_bset: result = fval | mask;
      default: result = fval;
    endcase
  end
endmodule

// >>> mie_core.sv
// Fetch, decode and execute core for the documented instruction subset
`timescale 1ns/1ps
`include "mie_consts.svh"
module mie_core #(
  parameter int PW = `MIE_PP_W,
  parameter int DW = `MIE_DATA_W,
  parameter int AW = `MIE_FA_W,
  parameter int WW = `MIE_WDOG_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  output logic [PW-1:0] pm_addr,
  input wire logic [`MIE_OPC_W-1:0] pm_rdata,
  output logic [AW-1:0] rf_raddr,
  input wire logic [DW-1:0] rf_rdata,
  output logic rf_we,
  output logic [AW-1:0] rf_waddr,
  output logic [DW-1:0] rf_wdata,
  output logic stack_push,
  output logic [PW-1:0] stack_head,
  output logic [DW-1:0] acc,
  output logic out_bit_flag,
  output logic nibble_overflow_flag,
  output logic null_result_flag,
  output logic expiry_flag,
  output logic powerdown_flag,
  output logic [WW-1:0] watchdog_counter
);
  logic [`MIE_OPC_W-1:0] instr;
  logic [PW-1:0] program_pointer;
  mie_pkg::mie_op_t op;
  logic [AW-1:0] fa;
  logic dst_file;
  logic [`MIE_BIT_W-1:0] bit_pos;
  logic [DW-1:0] imm;
  logic [PW-1:0] target;
  logic [DW-1:0] fval;
  logic [DW-1:0] result;
  logic alu_carry;
  logic alu_half;
  logic alu_zero;
  logic bit_val;
  logic skip;
  logic branch;
  logic to_file;
  logic to_acc;
  logic upd_arith;
  logic upd_zero;
  logic [PW-1:0] next_pp;
  logic [WW-1:0] next_wdog;

  mie_decode u_decode (
    .opcode(instr),
    .op(op),
    .fa(fa),
    .dst_file(dst_file),
    .bit_pos(bit_pos),
    .imm(imm),
    .target(target)
  );

  // A write issued last cycle has not reached the file yet, so forward it
  assign rf_raddr = fa;
  assign fval = (rf_we && rf_waddr == fa) ? rf_wdata : rf_rdata;

  mie_alu #(.DW(DW)) u_alu (
    .op(op),
    .acc(acc),
    .fval(fval),
    .imm(imm),
    .bit_pos(bit_pos),
    .result(result),
    .carry(alu_carry),
    .half(alu_half),
    .zero(alu_zero),
    .bit_val(bit_val)
  );

  assign pm_addr = program_pointer;

  always_comb begin
    skip = 1'b0;
    branch = 1'b0;
    to_file = 1'b0;
    to_acc = 1'b0;
    upd_arith = 1'b0;
    upd_zero = 1'b0;
    case (op)
      mie_pkg::op_add_lit: begin
        to_acc = 1'b1;
        upd_arith = 1'b1;
      end
      mie_pkg::op_add_f: begin
        to_file = dst_file;
        to_acc = ~dst_file;
        upd_arith = 1'b1;
      end
      mie_pkg::op_and_lit, mie_pkg::op_or_lit, mie_pkg::op_clr_acc: begin
        to_acc = 1'b1;
        upd_zero = 1'b1;
      end
      mie_pkg::op_and_f, mie_pkg::op_or_f, mie_pkg::op_com_f, mie_pkg::op_dec_f,
      mie_pkg::op_inc_f, mie_pkg::op_mov_f: begin
        to_file = dst_file;
        to_acc = ~dst_file;
        upd_zero = 1'b1;
      end
      mie_pkg::op_clr_f: begin
        to_file = 1'b1;
        upd_zero = 1'b1;
      end
      mie_pkg::op_decsz_f, mie_pkg::op_incsz_f: begin
        to_file = dst_file;
        to_acc = ~dst_file;
        skip = alu_zero;
      end
      mie_pkg::op_bclr, mie_pkg::op_bset: begin
        to_file = 1'b1;
      end
      mie_pkg::op_bskc: begin
        skip = ~bit_val;
      end
      mie_pkg::op_bsks: begin
        skip = bit_val;
      end
      mie_pkg::op_call, mie_pkg::op_jump: begin
        branch = 1'b1;
      end
      default: begin
        skip = 1'b0;
      end
    endcase
  end

  // Fetch address already points one past the executing opcode
  assign next_pp = branch ? target : program_pointer + `MIE_PP_STEP;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      program_pointer <= `MIE_PP_RST;
    end else if (ce) begin
      program_pointer <= next_pp;
    end
  end

  // A discarded opcode becomes a NOP slot: skips and branches cost one extra cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      instr <= `MIE_WORD_NOP;
    end else if (ce) begin
      instr <= (skip || branch) ? `MIE_WORD_NOP : pm_rdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stack_push <= 1'b0;
      stack_head <= `MIE_PP_RST;
    end else if (ce) begin
      stack_push <= (op == mie_pkg::op_call);
      if (op == mie_pkg::op_call) begin
        stack_head <= program_pointer;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rf_we <= 1'b0;
      rf_waddr <= '0;
      rf_wdata <= `MIE_ACC_RST;
    end else if (ce) begin
      rf_we <= to_file;
      if (to_file) begin
        rf_waddr <= fa;
        rf_wdata <= result;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      acc <= `MIE_ACC_RST;
    end else if (ce && to_acc) begin
      acc <= result;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_bit_flag <= `MIE_FLAG_RST;
      nibble_overflow_flag <= `MIE_FLAG_RST;
      null_result_flag <= `MIE_FLAG_RST;
    end else if (ce) begin
      if (upd_arith) begin
        out_bit_flag <= alu_carry;
        nibble_overflow_flag <= alu_half;
      end
      if (upd_arith || upd_zero) begin
        null_result_flag <= alu_zero;
      end
    end
  end

  // Free-running watchdog; a wrap marks expiry, a kick restarts it
  assign next_wdog = watchdog_counter + WW'(1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      watchdog_counter <= '0;
    end else if (ce) begin
      watchdog_counter <= (op == mie_pkg::op_kick) ? '0 : next_wdog;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      expiry_flag <= `MIE_WDFLAG_RST;
      powerdown_flag <= `MIE_WDFLAG_RST;
    end else if (ce) begin
      if (op == mie_pkg::op_kick) begin
        expiry_flag <= `MIE_WDFLAG_RST;
        powerdown_flag <= `MIE_WDFLAG_RST;
      end else if (next_wdog == '0) begin
        expiry_flag <= `MIE_FLAG_RST;
      end
    end
  end
endmodule

// >>> mie_mem_model.sv
// Program memory, register file and return stack facing the execute core
`timescale 1ns/1ps
module mie_mem_model (
  input wire logic clk_sys,
  input wire logic [12:0] pm_addr,
  output logic [15:0] pm_rdata,
  input wire logic [8:0] rf_raddr,
  output logic [7:0] rf_rdata,
  input wire logic rf_we,
  input wire logic [8:0] rf_waddr,
  input wire logic [7:0] rf_wdata,
  input wire logic stack_push,
  input wire logic [12:0] stack_head
);
  // Loaded by the bench only while the core is held in reset
  logic [15:0] rom [0:8191];
  logic [7:0] rf [0:511];
  logic [12:0] top = 13'h0000;
  int pushes = 0;
  // Asynchronous reads, as the core samples them in the same cycle
  assign pm_rdata = rom[pm_addr];
  assign rf_rdata = rf[rf_raddr];
  always @(posedge clk_sys) begin
    if (rf_we) begin
      rf[rf_waddr] <= rf_wdata;
    end
    if (stack_push) begin
      top <= stack_head;
      pushes <= pushes + 1;
    end
  end
endmodule

// >>> mie_core_checker.sv
// Port-level assertions for the execute core
`timescale 1ns/1ps
module mie_core_checker #(
  parameter int WW = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [12:0] pm_addr,
  input wire logic [15:0] pm_rdata,
  input wire logic [8:0] rf_raddr,
  input wire logic [7:0] rf_rdata,
  input wire logic rf_we,
  input wire logic [8:0] rf_waddr,
  input wire logic [7:0] rf_wdata,
  input wire logic stack_push,
  input wire logic [12:0] stack_head,
  input wire logic [7:0] acc,
  input wire logic out_bit_flag,
  input wire logic nibble_overflow_flag,
  input wire logic null_result_flag,
  input wire logic expiry_flag,
  input wire logic powerdown_flag,
  input wire logic [WW-1:0] watchdog_counter
);
  // Shadow of the executing opcode; a discarded fetch becomes a NOP
  logic [15:0] ex;
  logic [7:0] fv;
  logic [8:0] sum9;
  logic half;
  logic is_br;
  logic is_call;
  logic skip;
  logic [12:0] tgt;
  logic [8:0] fa;
  always_comb begin
    // The core forwards a pending write, so the shadow must too
    fv = (rf_we && rf_waddr == rf_raddr) ? rf_wdata : rf_rdata;
    sum9 = {1'b0, acc} + {1'b0, ex[7:0]};
    half = ({1'b0, acc[3:0]} + {1'b0, ex[3:0]}) > 5'h0F;
    is_br = ex[13:12] == 2'h2;
    is_call = is_br && !ex[11];
    tgt = {ex[15:14], ex[10:0]};
    fa = {ex[15:14], ex[6:0]};
    skip = (ex[13:11] == 3'h7 && fv[ex[9:7]] == ex[10]) || (ex[13:8] == 6'h0B && fv == 8'h01) ||
      (ex[13:8] == 6'h0F && fv == 8'hFF);
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ex <= 16'h0000;
    end else if (ce) begin
      ex <= (skip || is_br) ? 16'h0000 : pm_rdata;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  property p_read_addr;
    ce |-> rf_raddr == fa;
  endproperty
  a_read_addr: assert property (p_read_addr) else $error("file read address wrong");
  property p_add_lit;
    ce && ex[15:8] == 8'h1C |=> {out_bit_flag, acc} == $past(sum9) && nibble_overflow_flag == $past(half);
  endproperty
  a_add_lit: assert property (p_add_lit) else $error("literal add result or flags wrong");
  property p_dst_acc;
    ce && ex[13:12] == 2'h0 && !ex[7] |=> !rf_we;
  endproperty
  a_dst_acc: assert property (p_dst_acc) else $error("file written with accumulator target");
  property p_inc_write;
    ce && ex[13:8] == 6'h0A && ex[7] |=> rf_we && rf_waddr == $past(fa) && rf_wdata == $past(fv) + 8'h01;
  endproperty
  a_inc_write: assert property (p_inc_write) else $error("increment write-back wrong");
  property p_clr_acc;
    ce && ex == 16'h0140 |=> acc == 8'h00 && null_result_flag;
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("accumulator clear wrong");
  property p_kick;
    ce && ex == 16'h1E04 |=> watchdog_counter == '0 && expiry_flag && powerdown_flag;
  endproperty
  a_kick: assert property (p_kick) else $error("watchdog kick wrong");
  // Without this the kick check would pass even if a wrap never cleared expiry
  property p_wd_expire;
    ce && watchdog_counter == '1 && ex != 16'h1E04 |=> !expiry_flag;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog wrap did not clear expiry");
  property p_branch;
    ce && is_br |=> pm_addr == $past(tgt) ##1 !rf_we && !stack_push && pm_addr == $past(pm_addr) + 13'h1;
  endproperty
  a_branch: assert property (p_branch) else $error("branch target or empty slot wrong");
  property p_call_push;
    ce && is_call |=> stack_push && stack_head == $past(pm_addr);
  endproperty
  a_call_push: assert property (p_call_push) else $error("call return address wrong");
  property p_push_cause;
    stack_push |-> $past(is_call) && $past(ce);
  endproperty
  a_push_cause: assert property (p_push_cause) else $error("stack push without call");
  property p_skip_nop;
    ce && skip |=> pm_addr == $past(pm_addr) + 13'h1 ##1 !rf_we && acc == $past(acc);
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("skipped slot not empty");
  c_skip: cover property (ce && skip);
  c_call: cover property (ce && is_call);
  c_kick: cover property (ce && ex == 16'h1E04);
endmodule
bind mie_core mie_core_checker #(.WW(WW)) u_chk (.clk_sys, .rst, .ce, .pm_addr, .pm_rdata, .rf_raddr,
  .rf_rdata, .rf_we, .rf_waddr, .rf_wdata, .stack_push, .stack_head, .acc, .out_bit_flag,
  .nibble_overflow_flag, .null_result_flag, .expiry_flag, .powerdown_flag, .watchdog_counter);

// >>> mcu_instruction_execute_test.sv
// Self-checking bench for the execute core
`timescale 1ns/1ps
module mcu_instruction_execute_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [12:0] pm_addr;
  logic [15:0] pm_rdata;
  logic [8:0] rf_raddr;
  logic [7:0] rf_rdata;
  logic rf_we;
  logic [8:0] rf_waddr;
  logic [7:0] rf_wdata;
  logic stack_push;
  logic [12:0] stack_head;
  logic [7:0] acc;
  logic out_bit_flag;
  logic nibble_overflow_flag;
  logic null_result_flag;
  logic expiry_flag;
  logic powerdown_flag;
  logic [3:0] watchdog_counter;
  int fail_count = 0;
  int num_checks = 0;
  // Narrow watchdog so that it wraps inside a short program
  mie_core #(.WW(4)) DUT (.clk_sys, .rst, .ce, .pm_addr, .pm_rdata, .rf_raddr, .rf_rdata, .rf_we,
    .rf_waddr, .rf_wdata, .stack_push, .stack_head, .acc, .out_bit_flag, .nibble_overflow_flag,
    .null_result_flag, .expiry_flag, .powerdown_flag, .watchdog_counter);
  mie_mem_model MEM (.clk_sys, .pm_addr, .pm_rdata, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr,
    .rf_wdata, .stack_push, .stack_head);
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] bop(input logic [8:0] f, input logic [3:0] s, input logic d);
    return {f[8:7], 2'h0, s, d, f[6:0]};
  endfunction
  function automatic logic [15:0] bit_op(input logic [8:0] f, input logic [1:0] k, input logic [2:0] b);
    return {f[8:7], 2'h3, k, b, f[6:0]};
  endfunction
  function automatic logic [15:0] br(input logic j, input logic [12:0] t);
    return {t[12:11], 2'h2, j, t[10:0]};
  endfunction
  task automatic pg(input logic [12:0] a, input logic [15:0] w);
    MEM.rom[a] = w;
  endtask
  task automatic fs(input logic [8:0] a, input logic [7:0] v);
    MEM.rf[a] = v;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fail_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic hold();
    @(posedge clk_sys);
    rst <= 1'b1;
    MEM.pushes = 0;
    for (int i = 0; i < 8192; i++) begin
      MEM.rom[i] = 16'h0000;
    end
  endtask
  // Program ends in a jump to itself; the run is over once that jump executes
  task automatic run(input logic [12:0] h);
    int n;
    pg(h, br(1'b1, h));
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    n = 0;
    while (pm_addr !== h + 13'h1 && n < 400) begin
      @(negedge clk_sys);
      n++;
    end
    if (n == 400) begin
      fail_count++;
      $display("wrong value at %0t: halt loop never reached", $time);
      finish_test();
    end
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic s_alu();
    hold();
    fs(9'h1C2, 8'hC2);
    fs(9'h1FF, 8'h01);
    fs(9'h013, 8'h91);
    fs(9'h010, 8'h13);
    fs(9'h011, 8'h00);
    fs(9'h030, 8'h5A);
    pg(0, 16'h1C5A);
    pg(1, 16'h0140);
    pg(2, 16'h1C17);
    pg(3, bop(9'h1C2, 4'h7, 1'b0));
    pg(4, bop(9'h1FF, 4'h7, 1'b1));
    pg(5, 16'h1C27);
    pg(6, 16'h1AA3);
    pg(7, 16'h1B5F);
    pg(8, bop(9'h013, 4'h4, 1'b0));
    pg(9, bop(9'h1FF, 4'h5, 1'b1));
    pg(10, bop(9'h010, 4'h9, 1'b0));
    pg(11, bop(9'h030, 4'h1, 1'b1));
    pg(12, 16'h1A00);
    pg(13, bop(9'h011, 4'h8, 1'b1));
    run(13'h00E);
    check(acc, 8'hEC);
    check({5'h0, out_bit_flag, nibble_overflow_flag, null_result_flag}, 8'h07);
    check(MEM.rf[9'h1FF], 8'h92);
    check(MEM.rf[9'h030], 8'h00);
    check(MEM.rf[9'h011], 8'h00);
  endtask
  task automatic s_skip();
    hold();
    fs(9'h1C0, 8'hC7);
    fs(9'h040, 8'h0A);
    fs(9'h021, 8'hFF);
    fs(9'h020, 8'h01);
    fs(9'h022, 8'h01);
    fs(9'h023, 8'hFE);
    fs(9'h024, 8'hFF);
    fs(9'h025, 8'h05);
    pg(0, bit_op(9'h1C0, 2'h0, 3'h7));
    pg(1, bit_op(9'h040, 2'h1, 3'h7));
    pg(2, bit_op(9'h1C0, 2'h2, 3'h7));
    pg(3, 16'h1C01);
    pg(4, bit_op(9'h1C0, 2'h2, 3'h0));
    pg(5, 16'h1C02);
    pg(6, bit_op(9'h040, 2'h3, 3'h7));
    pg(7, 16'h1C04);
    pg(8, bit_op(9'h040, 2'h3, 3'h0));
    pg(9, 16'h1C08);
    pg(10, bop(9'h020, 4'h3, 1'b1));
    pg(11, bop(9'h021, 4'hA, 1'b1));
    pg(12, bop(9'h022, 4'hB, 1'b1));
    pg(13, 16'h1C01);
    pg(14, bop(9'h023, 4'hF, 1'b1));
    pg(15, 16'h1C10);
    pg(16, bop(9'h024, 4'hF, 1'b0));
    pg(17, 16'h1C04);
    pg(18, bop(9'h025, 4'hB, 1'b0));
    run(13'h013);
    check(acc, 8'h04);
    check({5'h0, out_bit_flag, nibble_overflow_flag, null_result_flag}, 8'h00);
    check(MEM.rf[9'h1C0], 8'h47);
    check(MEM.rf[9'h040], 8'h8A);
    check(MEM.rf[9'h020], 8'h00);
    check(MEM.rf[9'h021], 8'h00);
    check(MEM.rf[9'h022], 8'h00);
    check(MEM.rf[9'h023], 8'hFF);
    check(MEM.rf[9'h024], 8'hFF);
  endtask
  task automatic s_flow();
    hold();
    pg(0, 16'h1C01);
    pg(1, br(1'b1, 13'h0800));
    pg(2, 16'h1C40);
    pg(13'h0800, br(1'b0, 13'h1ABC));
    pg(13'h0801, 16'h1C80);
    pg(13'h1ABC, 16'h1C02);
    // Idle run before the kick lets the narrow watchdog wrap first
    pg(13'h1AD0, 16'h1E04);
    run(13'h1AD1);
    check(acc, 8'h03);
    check(MEM.top[7:0], 8'h01);
    check({3'h0, MEM.top[12:8]}, 8'h08);
    check(8'(MEM.pushes), 8'h01);
    check({6'h0, expiry_flag, powerdown_flag}, 8'h03);
    check({7'h0, watchdog_counter < 4'h4}, 8'h01);
  endtask
  initial begin
    s_alu();
    s_skip();
    s_flow();
    finish_test();
  end
endmodule
